// File: rtl/fce_host.sv
// Host controller that issues command sequences to a parallel flash.
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Unlock addresses use only the low eleven lines; upper lines driven zero.
// [R2] Unlocked commands open with AA at 555 then 55 at 2AA.
// [R3] Unlock pair then 90 at 555 enters identification mode.
// [R4] Unlock pair, A0 at 555, then target and value programs one byte.
// [R5] Unlock pair then 20 enters bypass; only bypass program and exit allowed.
// [R6] In bypass, 90 then 00 leaves bypass mode.
// [R7] Whole-array erase: unlock, 80, unlock, 10 at 555.
// [R8] Whole-array erase skips protected blocks; all protected ends quickly.
// [R9] During whole-array erase every command is ignored; reads give status.
// [R10] Clean erase returns to read mode; an error holds status until reset.
// [R11] Erase sets all bits of unprotected affected blocks to one.
// [R12] Block erase ends with 30 at a block; repeats add further blocks.
// [R13] Erase starts 50 us after last selection; later selections are refused.
// [R14] Host must add each further block within 50 us of the previous.
// [R15] From the sixth block erase write, reads return status.
// [R16] Block erase skips protected blocks; all protected ends quickly.
// [R17] During block erase only suspend and reset are honoured.
// [R18] B0 halts the block erase within 15 us, then read mode.
// [R19] Suspend in the selection window acts at once; resume closes it.
// [R20] While suspended, other blocks read and program normally.
// [R21] Identification in suspend; a reset returns to the suspended state.
// [R22] Writing 30 while suspended resumes; suspend and resume may repeat.
// [R23] An invalid sequence returns the device to array read.
// [R24] Reset during block erase or after an error takes up to 10 us.
// [R25] Status bit 6 alternates on successive reads while busy.
// [R26] Status bit 5 is set when a program or erase fails.
module fce_host #(
	parameter int AW = 19
) (
	input  wire logic                 clk_in,
	input  wire logic                 nrst_in,
	input  wire logic                 cmd_valid_in,
	input  wire fce_pkg::fce_cmd_type cmd_code_in,
	input  wire logic [AW-1:0]        cmd_addr_in,
	input  wire logic [7:0]           cmd_data_in,
	output logic                      cmd_ready_out,
	output logic                      done_out,
	output logic                      refused_out,
	output logic                      fail_out,
	output logic                      sel_open_out,
	output logic                      suspended_out,
	output logic [7:0]                rdata_out,
	output logic [AW-1:0]             flash_addr_out,
	output logic [7:0]                flash_dq_out,
	output logic                      flash_dq_oe_out,
	input  wire logic [7:0]           flash_dq_in,
	output logic                      flash_ce_n_out,
	output logic                      flash_oe_n_out,
	output logic                      flash_we_n_out
);
	fce_pkg::fce_state_type state_q, state_d;
	fce_pkg::fce_cmd_type   cmd_q, w_cmd;
	logic [AW-1:0]          addr_q, w_addr;
	logic [7:0]             data_q, prev_q, dq_s1_q, dq_s2_q;
	logic [2:0]             step_q, len_q, w_step;
	logic [fce_pkg::CNT_W-1:0] wait_q, sel_cnt_q;
	logic byp_q, auto_q, chip_q, blk_q, susp_q, first_q, fail_q;
	logic accept, poll_end, sel_open;

	////////////////////////////////////////////////////////////////////////
	// Number of bus writes in each command.
	function automatic logic [2:0] seq_len(fce_pkg::fce_cmd_type c);
		case (c)
		fce_pkg::CMD_RESET, fce_pkg::CMD_ADD_BLOCK, fce_pkg::CMD_SUSPEND,
		fce_pkg::CMD_RESUME: seq_len = 3'd1;
		fce_pkg::CMD_BYP_PROG, fce_pkg::CMD_BYP_EXIT: seq_len = 3'd2;
		fce_pkg::CMD_AUTOSEL, fce_pkg::CMD_BYP_ENTER: seq_len = 3'd3;
		fce_pkg::CMD_PROGRAM: seq_len = 3'd4;
		fce_pkg::CMD_CHIP, fce_pkg::CMD_BLOCK: seq_len = 3'd6;
		default: seq_len = 3'd0;
		endcase
	endfunction

	// Address and data of write number s of command c.
	function automatic logic [AW+7:0] seq_word(fce_pkg::fce_cmd_type c,
			logic [2:0] s, logic [AW-1:0] a, logic [7:0] d);
		logic [AW-1:0] fa;
		logic [7:0]    fd;
		fa = AW'((s[0] ^ (s > 3'd2)) ? fce_pkg::ADR_UNLK2 : fce_pkg::ADR_UNLK1); // R1 R2
		fd = (s == 3'd0 || s == 3'd3) ? fce_pkg::D_UNLK1 : fce_pkg::D_UNLK2; // R2
		case (c)
		fce_pkg::CMD_AUTOSEL: if (s == 3'd2) fd = fce_pkg::D_AUTOSEL; // R3
		fce_pkg::CMD_BYP_ENTER: if (s == 3'd2) fd = fce_pkg::D_BYPASS; // R5
		fce_pkg::CMD_PROGRAM: begin
			if (s == 3'd2) fd = fce_pkg::D_PROGRAM;
			if (s == 3'd3) {fa, fd} = {a, d}; // R4
		end
		fce_pkg::CMD_BYP_PROG: {fa, fd} = (s == 3'd0) ?
			{fa, fce_pkg::D_PROGRAM} : {a, d}; // R5
		fce_pkg::CMD_BYP_EXIT: fd = (s == 3'd0) ?
			fce_pkg::D_AUTOSEL : fce_pkg::D_BYP_END; // R6
		fce_pkg::CMD_CHIP, fce_pkg::CMD_BLOCK: begin
			if (s == 3'd2) fd = fce_pkg::D_ERASE;
			if (s == 3'd5 && c == fce_pkg::CMD_CHIP) fd = fce_pkg::D_CHIP; // R7
			if (s == 3'd5 && c == fce_pkg::CMD_BLOCK) begin
				{fa, fd} = {a, fce_pkg::D_BLOCK}; // R12
			end
		end
		fce_pkg::CMD_ADD_BLOCK: {fa, fd} = {a, fce_pkg::D_BLOCK}; // R12
		fce_pkg::CMD_SUSPEND: fd = fce_pkg::D_SUSPEND; // R18
		fce_pkg::CMD_RESUME: fd = fce_pkg::D_RESUME; // R22
		fce_pkg::CMD_RESET: fd = fce_pkg::D_RESET;
		default: fd = fd;
		endcase
		seq_word = {fa, fd};
	endfunction

	// Commands that are legal in the present device mode.
	function automatic logic cmd_ok(fce_pkg::fce_cmd_type c, logic so);
		if (fail_q)
			cmd_ok = c inside {fce_pkg::CMD_RESET, fce_pkg::CMD_READ}; // R10
		else if (chip_q)
			cmd_ok = 1'b0; // R9
		else if (susp_q)
			cmd_ok = c inside {fce_pkg::CMD_READ, fce_pkg::CMD_PROGRAM,
				fce_pkg::CMD_AUTOSEL, fce_pkg::CMD_RESUME,
				fce_pkg::CMD_RESET}; // R20 R21 R22
		else if (blk_q)
			cmd_ok = c inside {fce_pkg::CMD_POLL, fce_pkg::CMD_SUSPEND,
				fce_pkg::CMD_RESET, fce_pkg::CMD_READ} ||
				(c == fce_pkg::CMD_ADD_BLOCK && so); // R13 R14 R17
		else if (byp_q)
			cmd_ok = c inside {fce_pkg::CMD_BYP_PROG, fce_pkg::CMD_BYP_EXIT,
				fce_pkg::CMD_READ}; // R5
		else
			cmd_ok = !(c inside {fce_pkg::CMD_BYP_PROG, fce_pkg::CMD_BYP_EXIT,
				fce_pkg::CMD_ADD_BLOCK, fce_pkg::CMD_SUSPEND,
				fce_pkg::CMD_RESUME, fce_pkg::CMD_POLL}); // R23
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Handshake decode and the step that the next write will use.
	assign sel_open = blk_q && !susp_q && (sel_cnt_q < fce_pkg::CNT_W'(fce_pkg::SEL_CYC));
	// A process, so that the mode flags read inside cmd_ok wake it up too.
	always_comb begin
		accept = state_q == fce_pkg::S_IDLE && cmd_valid_in &&
			cmd_ok(cmd_code_in, sel_open);
	end
	assign poll_end = state_q == fce_pkg::S_RD_CAP &&
		state_d == fce_pkg::S_IDLE && cmd_q != fce_pkg::CMD_READ;
	assign cmd_ready_out = state_q == fce_pkg::S_IDLE;
	assign sel_open_out  = sel_open;
	assign suspended_out = susp_q;
	assign fail_out      = fail_q;
	assign w_cmd  = (state_q == fce_pkg::S_IDLE) ? cmd_code_in : cmd_q;
	assign w_addr = (state_q == fce_pkg::S_IDLE) ? cmd_addr_in : addr_q;
	assign w_step = (state_q == fce_pkg::S_IDLE) ? 3'd0 : step_q + 3'd1;

	// Next state of the bus sequencer.
	always_comb begin
		state_d = state_q;
		case (state_q)
		fce_pkg::S_IDLE: begin
			if (accept)
				state_d = (seq_len(cmd_code_in) != 3'd0) ?
					fce_pkg::S_WR_SET : fce_pkg::S_RD_SET;
		end
		fce_pkg::S_WR_SET: state_d = fce_pkg::S_WR_PUL;
		fce_pkg::S_WR_PUL: state_d = fce_pkg::S_WR_END;
		fce_pkg::S_WR_END: begin
			if (step_q != len_q - 3'd1)
				state_d = fce_pkg::S_WR_SET;
			else if (cmd_q inside {fce_pkg::CMD_PROGRAM, fce_pkg::CMD_BYP_PROG,
					fce_pkg::CMD_CHIP})
				state_d = fce_pkg::S_RD_SET; // R15
			else if (cmd_q inside {fce_pkg::CMD_SUSPEND, fce_pkg::CMD_RESET})
				state_d = fce_pkg::S_WAIT; // R18 R24
			else
				state_d = fce_pkg::S_IDLE;
		end
		fce_pkg::S_RD_SET: state_d = fce_pkg::S_RD_W1;
		fce_pkg::S_RD_W1:  state_d = fce_pkg::S_RD_W2;
		fce_pkg::S_RD_W2:  state_d = fce_pkg::S_RD_CAP;
		fce_pkg::S_RD_CAP: begin
			if (cmd_q == fce_pkg::CMD_READ || (!first_q &&
					(prev_q[fce_pkg::BIT_TOGGLE] == dq_s2_q[fce_pkg::BIT_TOGGLE] ||
					(prev_q[fce_pkg::BIT_FAIL] && dq_s2_q[fce_pkg::BIT_FAIL]))))
				state_d = fce_pkg::S_IDLE; // R25 R26
			else
				state_d = fce_pkg::S_RD_SET;
		end
		fce_pkg::S_WAIT: begin
			if (wait_q == '0)
				state_d = fce_pkg::S_IDLE;
		end
		default: state_d = fce_pkg::S_IDLE;
		endcase
	end

	// Sequencer state and per-command bookkeeping.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= fce_pkg::S_IDLE;
			cmd_q   <= fce_pkg::CMD_READ;
			addr_q  <= '0;
			data_q  <= 8'h00;
			len_q   <= 3'd0;
			step_q  <= 3'd0;
			first_q <= 1'b1;
			prev_q  <= 8'h00;
			wait_q  <= '0;
		end else begin
			state_q <= state_d;
			if (accept) begin
				cmd_q   <= cmd_code_in;
				addr_q  <= cmd_addr_in;
				data_q  <= cmd_data_in;
				len_q   <= seq_len(cmd_code_in);
				step_q  <= 3'd0;
				first_q <= 1'b1;
			end
			if (state_q == fce_pkg::S_WR_END)
				step_q <= step_q + 3'd1;
			if (state_q == fce_pkg::S_RD_CAP) begin
				first_q <= 1'b0;
				prev_q  <= dq_s2_q;
			end
			if (state_q == fce_pkg::S_WR_END && state_d == fce_pkg::S_WAIT)
				wait_q <= (cmd_q == fce_pkg::CMD_SUSPEND) ?
					fce_pkg::CNT_W'(fce_pkg::SUSP_CYC - 1) :
					fce_pkg::CNT_W'(fce_pkg::ABORT_CYC - 1); // R18 R24
			else if (state_q == fce_pkg::S_WAIT)
				wait_q <= wait_q - 1'b1;
		end
	end

	// Device mode as the host tracks it, plus the error flag.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{byp_q, auto_q, chip_q, blk_q, susp_q, fail_q} <= 6'h00;
		end else if (accept) begin
			case (cmd_code_in)
			fce_pkg::CMD_BYP_ENTER: byp_q <= 1'b1; // R5
			fce_pkg::CMD_BYP_EXIT:  byp_q <= 1'b0; // R6
			fce_pkg::CMD_AUTOSEL:   auto_q <= 1'b1; // R3
			fce_pkg::CMD_CHIP:      chip_q <= 1'b1; // R9
			fce_pkg::CMD_BLOCK:     blk_q <= 1'b1; // R17
			fce_pkg::CMD_SUSPEND:   susp_q <= 1'b1; // R19
			fce_pkg::CMD_RESUME:    susp_q <= 1'b0; // R22
			fce_pkg::CMD_RESET: begin
				auto_q <= 1'b0;
				fail_q <= 1'b0; // R10
				if (!(susp_q && auto_q))
					{chip_q, blk_q, susp_q} <= 3'b000; // R21
			end
			default: fail_q <= fail_q;
			endcase
		end else if (poll_end) begin
			if (dq_s2_q[fce_pkg::BIT_FAIL] && prev_q[fce_pkg::BIT_FAIL] &&
					prev_q[fce_pkg::BIT_TOGGLE] != dq_s2_q[fce_pkg::BIT_TOGGLE])
				fail_q <= 1'b1; // R26
			else if (cmd_q inside {fce_pkg::CMD_CHIP, fce_pkg::CMD_POLL})
				{chip_q, blk_q} <= 2'b00; // R8 R10 R16
		end
	end

	// Selection window counter, restarted by each block selection.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			sel_cnt_q <= fce_pkg::CNT_W'(fce_pkg::SEL_CYC);
		else if (accept && cmd_code_in inside {fce_pkg::CMD_BLOCK,
				fce_pkg::CMD_ADD_BLOCK})
			sel_cnt_q <= '0; // R13 R14
		else if (accept && cmd_code_in inside {fce_pkg::CMD_SUSPEND,
				fce_pkg::CMD_RESUME})
			sel_cnt_q <= fce_pkg::CNT_W'(fce_pkg::SEL_CYC); // R19
		else if (sel_cnt_q != fce_pkg::CNT_W'(fce_pkg::SEL_CYC))
			sel_cnt_q <= sel_cnt_q + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Flash pins, all from flip-flops loaded from the next state.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flash_ce_n_out  <= 1'b1;
			flash_oe_n_out  <= 1'b1;
			flash_we_n_out  <= 1'b1;
			flash_dq_oe_out <= 1'b0;
			flash_addr_out  <= '0;
			flash_dq_out    <= 8'h00;
		end else begin
			flash_ce_n_out  <= state_d inside {fce_pkg::S_IDLE, fce_pkg::S_WAIT};
			// Output enable rises between polls, so each is a new bus read.
			flash_oe_n_out  <= !(state_d inside {fce_pkg::S_RD_W1,
				fce_pkg::S_RD_W2, fce_pkg::S_RD_CAP}); // R25
			flash_we_n_out  <= state_d != fce_pkg::S_WR_PUL;
			flash_dq_oe_out <= state_d inside {fce_pkg::S_WR_SET,
				fce_pkg::S_WR_PUL, fce_pkg::S_WR_END};
			if (state_d == fce_pkg::S_WR_SET)
				{flash_addr_out, flash_dq_out} <=
					seq_word(w_cmd, w_step, w_addr, cmd_data_in ^ data_q ^
					((state_q == fce_pkg::S_IDLE) ? data_q : cmd_data_in));
			else if (state_d == fce_pkg::S_RD_SET)
				flash_addr_out <= w_addr;
		end
	end

	// Read data passes two flip-flops before any logic looks at it.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dq_s1_q     <= 8'h00;
			dq_s2_q     <= 8'h00;
			rdata_out   <= 8'h00;
			done_out    <= 1'b0;
			refused_out <= 1'b0;
		end else begin
			dq_s1_q     <= flash_dq_in;
			dq_s2_q     <= dq_s1_q;
			done_out    <= state_q != fce_pkg::S_IDLE && state_d == fce_pkg::S_IDLE;
			refused_out <= state_q == fce_pkg::S_IDLE && cmd_valid_in && !accept;
			if (state_q == fce_pkg::S_RD_CAP)
				rdata_out <= dq_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the driven command sequences.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_unlock_pair: assert property (state_q == fce_pkg::S_WR_PUL && step_q == 3'd1 && // R2
		cmd_q inside {fce_pkg::CMD_AUTOSEL, fce_pkg::CMD_PROGRAM, fce_pkg::CMD_CHIP}
		|-> flash_dq_out == fce_pkg::D_UNLK2 && $past(flash_dq_out, 3) == fce_pkg::D_UNLK1)
		else $error("unlock pair not AA then 55");
	a_upper_zero: assert property (state_q == fce_pkg::S_WR_PUL && step_q < 3'd3 && // R1
		cmd_q inside {fce_pkg::CMD_AUTOSEL, fce_pkg::CMD_CHIP}
		|-> flash_addr_out[AW-1:11] == '0)
		else $error("upper address lines driven in unlock");
	a_autosel_code: assert property (state_q == fce_pkg::S_WR_PUL && step_q == 3'd2 && // R3
		cmd_q == fce_pkg::CMD_AUTOSEL |-> flash_dq_out == fce_pkg::D_AUTOSEL)
		else $error("identification code wrong");
	a_prog_target: assert property (state_q == fce_pkg::S_WR_PUL && step_q == 3'd3 && // R4
		cmd_q == fce_pkg::CMD_PROGRAM |-> flash_addr_out == addr_q && flash_dq_out == data_q)
		else $error("program target or value wrong");
	a_byp_exit: assert property (state_q == fce_pkg::S_WR_PUL && step_q == 3'd1 && // R6
		cmd_q == fce_pkg::CMD_BYP_EXIT |-> flash_dq_out == fce_pkg::D_BYP_END &&
		$past(flash_dq_out, 3) == fce_pkg::D_AUTOSEL)
		else $error("bypass exit not 90 then 00");
	a_chip_last: assert property (state_q == fce_pkg::S_WR_PUL && step_q == 3'd5 && // R7
		cmd_q == fce_pkg::CMD_CHIP |-> flash_dq_out == fce_pkg::D_CHIP &&
		flash_addr_out[10:0] == fce_pkg::ADR_UNLK1)
		else $error("chip erase final write wrong");
	a_sel_window: assert property ($rose(state_q == fce_pkg::S_WR_SET) && // R14
		cmd_q == fce_pkg::CMD_ADD_BLOCK |->
		$past(sel_cnt_q) < fce_pkg::CNT_W'(fce_pkg::SEL_CYC) && flash_dq_out == fce_pkg::D_BLOCK)
		else $error("block added outside the window");
	a_susp_wait: assert property (state_q == fce_pkg::S_WR_END && // R18
		cmd_q == fce_pkg::CMD_SUSPEND && step_q == 3'd0 |=> state_q == fce_pkg::S_WAIT
		[*8] ##0 wait_q == fce_pkg::CNT_W'(fce_pkg::SUSP_CYC - 8))
		else $error("suspend wait too short");
	a_fail_flag: assert property (state_q == fce_pkg::S_RD_CAP && !first_q && // R26
		cmd_q != fce_pkg::CMD_READ && dq_s2_q[fce_pkg::BIT_FAIL] &&
		prev_q[fce_pkg::BIT_FAIL] &&
		prev_q[fce_pkg::BIT_TOGGLE] != dq_s2_q[fce_pkg::BIT_TOGGLE] |=> fail_q && done_out)
		else $error("failure not reported");
	a_we_pulse: assert property ($fell(flash_we_n_out) |=> flash_we_n_out && // R2
		flash_dq_oe_out) else $error("write pulse not one cycle");

	c_program: cover property (poll_end && cmd_q == fce_pkg::CMD_PROGRAM);
	c_add_block: cover property (accept && cmd_code_in == fce_pkg::CMD_ADD_BLOCK);
	c_suspend: cover property (susp_q && accept && cmd_code_in == fce_pkg::CMD_RESUME);
	c_fail: cover property ($rose(fail_q));
endmodule

// File: rtl/fce_pkg.sv
// Constants and types for the flash command and erase host controller.
package fce_pkg;
	// Clock rate and documented waits, converted to clock cycles.
	localparam int          CLK_MHZ   = 10;
	localparam int          SEL_US    = 50;
	localparam int          SUSP_US   = 15;
	localparam int          ABORT_US  = 10;
	localparam int          SEL_CYC   = SEL_US * CLK_MHZ;
	localparam int          SUSP_CYC  = SUSP_US * CLK_MHZ;
	localparam int          ABORT_CYC = ABORT_US * CLK_MHZ;
	localparam int          CNT_W     = 9;
	// Command addresses on the eleven decoded address lines.
	localparam logic [10:0] ADR_UNLK1 = 11'h555;
	localparam logic [10:0] ADR_UNLK2 = 11'h2AA;
	// Command data codes.
	localparam logic [7:0]  D_UNLK1   = 8'hAA;
	localparam logic [7:0]  D_UNLK2   = 8'h55;
	localparam logic [7:0]  D_RESET   = 8'hF0;
	localparam logic [7:0]  D_AUTOSEL = 8'h90;
	localparam logic [7:0]  D_PROGRAM = 8'hA0;
	localparam logic [7:0]  D_BYPASS  = 8'h20;
	localparam logic [7:0]  D_ERASE   = 8'h80;
	localparam logic [7:0]  D_CHIP    = 8'h10;
	localparam logic [7:0]  D_BLOCK   = 8'h30;
	localparam logic [7:0]  D_SUSPEND = 8'hB0;
	localparam logic [7:0]  D_RESUME  = 8'h30;
	localparam logic [7:0]  D_BYP_END = 8'h00;
	// Status bit positions.
	localparam int          BIT_TOGGLE = 6;
	localparam int          BIT_FAIL   = 5;

	// Commands accepted on the user port.
	typedef enum logic [3:0] {
		CMD_READ      = 4'h0,
		CMD_RESET     = 4'h1,
		CMD_AUTOSEL   = 4'h2,
		CMD_PROGRAM   = 4'h3,
		CMD_BYP_ENTER = 4'h4,
		CMD_BYP_PROG  = 4'h5,
		CMD_BYP_EXIT  = 4'h6,
		CMD_CHIP      = 4'h7,
		CMD_BLOCK     = 4'h8,
		CMD_ADD_BLOCK = 4'h9,
		CMD_SUSPEND   = 4'hA,
		CMD_RESUME    = 4'hB,
		CMD_POLL      = 4'hC
	} fce_cmd_type;

	// Bus sequencer states, Gray coded along the write and read paths.
	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_WR_SET = 4'h1,
		S_WR_PUL = 4'h3,
		S_WR_END = 4'h2,
		S_RD_SET = 4'h6,
		S_RD_W1  = 4'h7,
		S_RD_W2  = 4'h5,
		S_RD_CAP = 4'h4,
		S_WAIT   = 4'hC
	} fce_state_type;
endpackage

// File: bench/fce_flash_model.sv
// Behavioural model of the byte-wide flash that the host controller drives.
`timescale 1ns/1ps
module fce_flash_model #(
	parameter logic [7:0] ID_CODE = 8'h5C, // Arbitrary identity value.
	parameter logic [7:0] PROT    = 8'h00
) (
	input  wire logic [18:0] addr_in,
	input  wire logic [7:0]  dq_in,
	input  wire logic        ce_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic        fail_in,
	output logic [7:0]       dq_out
);
	logic [7:0]  mem [0:127];
	logic [7:0]  sel = 8'h00, pd = 8'h00;
	logic [18:0] pa = 19'h00000;
	logic [1:0]  op = 2'h0;
	logic        auto = 1'b0, byp = 1'b0, busy = 1'b0, susp = 1'b0;
	logic        selw = 1'b0, err = 1'b0, tog = 1'b0;
	int          step = 0, left = 0;

	////////////////////////////////////////////////////////////////////////
	// Starts an operation that stays busy for four status reads.
	task automatic start(input logic [1:0] kind);
		op = kind;
		busy = 1'b1;
		left = 4;
	endtask
	// Ends an operation; erases pass over protected blocks silently.
	task automatic finish();
		busy = 1'b0;
		for (int i = 0; i < 128; i++)
			if (!PROT[i/16] && (op == 2'h1 || (op == 2'h2 && sel[i/16])))
				mem[i] = 8'hFF;
		if (op == 2'h0)
			mem[{pa[18:16], pa[3:0]}] &= pd;
		if (op == 2'h2)
			sel = 8'h00;
	endtask
	initial begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'hFF;
		dq_out = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Command decoder, advanced on each rising write strobe.
	always @(posedge we_n_in) begin : decode
		logic [10:0] a;
		int          nxt;
		a = addr_in[10:0];
		nxt = 0;
		if (dq_in == 8'hF0 && (!busy || err || op == 2'h2)) begin
			busy = 1'b0;
			err = 1'b0;
			auto = 1'b0;
		end else if (busy) begin
			if (op == 2'h2 && dq_in == 8'hB0) begin
				busy = 1'b0;
				susp = 1'b1;
			end
			if (op == 2'h2 && dq_in == 8'h30 && selw)
				sel[addr_in[18:16]] = 1'b1;
			nxt = step;
		end else if (step == 3 || step == 7) begin
			pa = addr_in;
			pd = dq_in;
			err = fail_in;
			start(2'h0);
		end else if (byp) begin
			if (step == 0 && dq_in == 8'hA0) nxt = 7;
			if (step == 0 && dq_in == 8'h90) nxt = 8;
			if (step == 8 && dq_in == 8'h00) byp = 1'b0;
		end else if (susp && step == 0 && dq_in == 8'h30) begin
			susp = 1'b0;
			selw = 1'b0;
			start(2'h2);
		end else begin
			if ((step == 0 || step == 4) && a == 11'h555 && dq_in == 8'hAA)
				nxt = step + 1;
			if ((step == 1 || step == 5) && a == 11'h2AA && dq_in == 8'h55)
				nxt = step + 1;
			if (step == 2 && a == 11'h555) begin
				auto = dq_in == 8'h90;
				byp = dq_in == 8'h20;
				nxt = dq_in == 8'hA0 ? 3 : (dq_in == 8'h80 ? 4 : 0);
			end
			if (step == 6 && a == 11'h555 && dq_in == 8'h10)
				start(2'h1);
			if (step == 6 && dq_in == 8'h30) begin
				sel[addr_in[18:16]] = 1'b1;
				selw = 1'b1;
				start(2'h2);
			end
		end
		step = nxt;
	end

	// Read port: status while busy or on a suspended block, the identity code in identification mode, else the array.
	always @(negedge oe_n_in) begin
		#1;
		if (ce_n_in) begin
		end else if (busy) begin
			tog = ~tog;
			dq_out = {op == 2'h0 ? ~pd[7] : 1'b0, tog, err, 5'h00};
			if (!err && left > 0) left = left - 1;
			if (!err && left == 0) finish();
		end else if (susp && sel[addr_in[18:16]]) dq_out = {2'h2, 6'h00};
		else if (auto) dq_out = ID_CODE;
		else dq_out = mem[{addr_in[18:16], addr_in[3:0]}];
	end
	// A released data bus shows the inverse of its last value.
	always @(posedge oe_n_in) dq_out = ~dq_out;
endmodule

// File: bench/flash_command_erase_control_tb_top.sv
// Self-checking bench for the flash command host controller.
`timescale 1ns/1ps
`define CHK(a, b) begin \
	checked++; \
	if ((a) !== (b)) begin \
		fail_count++; \
		$display("unexpected at %0t: got %h expected %h", $time, a, b); \
	end \
end
module flash_command_erase_control_tb_top;
	localparam logic [7:0] ID = 8'h5C; // Arbitrary identity value.
	logic                 clk_in = 1'b0, nrst_in = 1'b0, cmd_valid_in = 1'b0;
	logic                 fail = 1'b0;
	fce_pkg::fce_cmd_type cmd_code_in = fce_pkg::CMD_READ;
	logic [18:0]          cmd_addr_in = 19'h00000, flash_addr_out;
	logic [7:0]           cmd_data_in = 8'h00, rdata_out, flash_dq_out, mdl_dq;
	logic                 cmd_ready_out, done_out, refused_out, fail_out;
	logic                 sel_open_out, suspended_out, flash_dq_oe_out;
	logic                 flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
	logic [26:0]          wq [$];
	int                   fail_count = 0, checked = 0, cyc = 0;
	wire  [7:0]           dq_bus = flash_dq_oe_out ? flash_dq_out : mdl_dq;

	fce_host i_fce_host (.clk_in(clk_in), .nrst_in(nrst_in),
		.cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
		.cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
		.cmd_ready_out(cmd_ready_out), .done_out(done_out),
		.refused_out(refused_out), .fail_out(fail_out),
		.sel_open_out(sel_open_out), .suspended_out(suspended_out),
		.rdata_out(rdata_out), .flash_addr_out(flash_addr_out),
		.flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out),
		.flash_dq_in(dq_bus), .flash_ce_n_out(flash_ce_n_out),
		.flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out));
	fce_flash_model #(.ID_CODE(ID)) i_fce_flash_model (
		.addr_in(flash_addr_out), .dq_in(dq_bus), .ce_n_in(flash_ce_n_out),
		.oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out), .fail_in(fail),
		.dq_out(mdl_dq));

	////////////////////////////////////////////////////////////////////////
	// Clock, hang limit and the log of completed bus writes.
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			final_report();
		end
	end
	always @(posedge flash_we_n_out) wq.push_back({flash_addr_out, dq_bus});

	// Issues one command, waits for done or refusal and checks which came.
	task automatic req(input fce_pkg::fce_cmd_type c, input logic [18:0] a,
			input logic [7:0] d, input logic rf);
		wq.delete();
		@(negedge clk_in);
		cmd_code_in = c;
		cmd_addr_in = a;
		cmd_data_in = d;
		cmd_valid_in = 1'b1;
		@(posedge clk_in);
		@(negedge clk_in);
		cmd_valid_in = 1'b0;
		for (int n = 0; n < 3000 && done_out !== 1'b1; n++)
			if (refused_out !== 1'b1) @(negedge clk_in);
			else break;
		`CHK({done_out, refused_out, cmd_ready_out}, {!rf, rf, 1'b1})
	endtask
	task automatic rd(input logic [18:0] a, input logic [7:0] e);
		req(fce_pkg::CMD_READ, a, 8'h00, 1'b0);
		`CHK(rdata_out, e)
	endtask
	task automatic wr(input int i, input logic [18:0] a, input logic [7:0] d);
		`CHK(wq[i], {a, d})
	endtask
	task automatic unl(input int i);
		wr(i, 19'h00555, 8'hAA);
		wr(i + 1, 19'h002AA, 8'h55);
	endtask
	task automatic final_report();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Program, identification and bypass sequences on the wire.
	task automatic t_prog();
		req(fce_pkg::CMD_PROGRAM, 19'h12345, 8'h5A, 1'b0);
		`CHK(wq.size(), 4)
		unl(0);
		wr(2, 19'h00555, 8'hA0);
		wr(3, 19'h12345, 8'h5A);
		rd(19'h12345, 8'h5A);
		req(fce_pkg::CMD_AUTOSEL, 19'h00000, 8'h00, 1'b0);
		wr(2, 19'h00555, 8'h90);
		rd(19'h00000, ID);
		req(fce_pkg::CMD_RESET, 19'h00000, 8'h00, 1'b0);
		rd(19'h12345, 8'h5A);
		req(fce_pkg::CMD_BYP_ENTER, 19'h00000, 8'h00, 1'b0);
		wr(2, 19'h00555, 8'h20);
		req(fce_pkg::CMD_PROGRAM, 19'h10001, 8'h11, 1'b1);
		req(fce_pkg::CMD_BYP_PROG, 19'h40006, 8'h66, 1'b0);
		`CHK(wq[0][7:0], 8'hA0)
		wr(1, 19'h40006, 8'h66);
		rd(19'h40006, 8'h66);
		req(fce_pkg::CMD_BYP_EXIT, 19'h00000, 8'h00, 1'b0);
		`CHK({wq[0][7:0], wq[1][7:0]}, 16'h9000)
		req(fce_pkg::CMD_BYP_PROG, 19'h40007, 8'h77, 1'b1);
	endtask
	// A failing program holds the error until a reset clears it.
	task automatic t_fail();
		fail = 1'b1;
		req(fce_pkg::CMD_PROGRAM, 19'h50008, 8'h00, 1'b0);
		`CHK(fail_out, 1'b1)
		req(fce_pkg::CMD_PROGRAM, 19'h50008, 8'h00, 1'b1);
		fail = 1'b0;
		req(fce_pkg::CMD_RESET, 19'h00000, 8'h00, 1'b0);
		`CHK({fail_out, wq[wq.size() - 1][7:0]}, 9'h0F0)
		rd(19'h50008, 8'hFF);
	endtask
	// Two-block erase with a suspend, a program and a resume in between.
	task automatic t_block();
		logic tgl;
		req(fce_pkg::CMD_PROGRAM, 19'h20003, 8'hB3, 1'b0);
		req(fce_pkg::CMD_BLOCK, 19'h20000, 8'h00, 1'b0);
		unl(0);
		wr(2, 19'h00555, 8'h80);
		unl(3);
		wr(5, 19'h20000, 8'h30);
		`CHK(sel_open_out, 1'b1)
		req(fce_pkg::CMD_ADD_BLOCK, 19'h30000, 8'h00, 1'b0);
		wr(0, 19'h30000, 8'h30);
		req(fce_pkg::CMD_PROGRAM, 19'h10002, 8'h22, 1'b1);
		req(fce_pkg::CMD_READ, 19'h20003, 8'h00, 1'b0);
		`CHK({rdata_out[7], rdata_out[5]}, 2'b00)
		tgl = rdata_out[6];
		req(fce_pkg::CMD_READ, 19'h20003, 8'h00, 1'b0);
		`CHK(rdata_out[6], !tgl)
		req(fce_pkg::CMD_SUSPEND, 19'h00000, 8'h00, 1'b0);
		`CHK({suspended_out, wq[0][7:0]}, 9'h1B0)
		req(fce_pkg::CMD_PROGRAM, 19'h50009, 8'h99, 1'b0);
		rd(19'h50009, 8'h99);
		req(fce_pkg::CMD_READ, 19'h20003, 8'h00, 1'b0);
		`CHK(rdata_out[7], 1'b1)
		`CHK(rdata_out[5:0], 6'h00)
		req(fce_pkg::CMD_RESUME, 19'h00000, 8'h00, 1'b0);
		`CHK({suspended_out, sel_open_out, wq[0][7:0]}, 10'h030)
		req(fce_pkg::CMD_ADD_BLOCK, 19'h60000, 8'h00, 1'b1);
		req(fce_pkg::CMD_POLL, 19'h00000, 8'h00, 1'b0);
		rd(19'h20003, 8'hFF);
		rd(19'h50009, 8'h99);
	endtask
	// Whole-array erase, after a suspend that is not legal outside erase.
	task automatic t_chip();
		req(fce_pkg::CMD_SUSPEND, 19'h00000, 8'h00, 1'b1);
		`CHK(wq.size(), 0)
		req(fce_pkg::CMD_CHIP, 19'h00000, 8'h00, 1'b0);
		unl(0);
		wr(2, 19'h00555, 8'h80);
		unl(3);
		wr(5, 19'h00555, 8'h10);
		rd(19'h12345, 8'hFF);
		rd(19'h50009, 8'hFF);
	endtask

	initial begin
		repeat (10) @(posedge clk_in);
		@(negedge clk_in);
		nrst_in = 1'b1;
		t_prog();
		t_fail();
		t_block();
		t_chip();
		final_report();
	end
endmodule
